// *** gpio_pkg.sv ***
package gpio_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] DATA_OFFS   = 12'h000;
    localparam logic [11:0] DIR_OFFS    = 12'h004;
    localparam logic [11:0] OPT_OFFS    = 12'h008;
    localparam logic [11:0] SENSE_OFFS  = 12'h00C;
    localparam logic [11:0] STATUS_OFFS = 12'h010;
    // Field positions in the sensitivity register
    localparam int          SENSE_LSB   = 0;
    localparam int          SENSE_W     = 2;
    // Status register fields
    localparam int          ST_PEND_POS = 0;
    localparam int          ST_LINE_POS = 1;
    // Reset values
    localparam logic [7:0]  PORT_RESET  = 8'h00;
    localparam logic [1:0]  SENSE_RESET = 2'h0;
    localparam int          PORT_W      = 8;

    // Sensitivity encodings
    typedef enum logic [1:0] {
        SENSE_FALL_LOW = 2'b00,
        SENSE_RISE     = 2'b01,
        SENSE_FALL     = 2'b10,
        SENSE_BOTH     = 2'b11
    } sense_t;
endpackage

// *** gpio_sync.sv ***
`timescale 1ns/1ps
module gpio_sync
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Levels
    input  wire logic [PORT_W-1:0] async_in,
    output logic      [PORT_W-1:0] sync_out
);
    typedef struct packed {
        logic [PORT_W-1:0] stage1;
        logic [PORT_W-1:0] stage2;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // First stage feeds only the second stage
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage2;
endmodule

// *** gpio_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Eight pins, each independently input, interrupt input, or output.
// RULE_02: Bit X of every port register serves pin X.
// RULE_03: Direction clear makes an input; data read returns the pin level.
// RULE_04: Data writes in input mode only change the latch.
// RULE_05: Direction set drives the latch; data read returns the latch.
// RULE_06: Option picks push-pull or open-drain; open-drain releases on one.
// RULE_07: Input option picks floating or pull-up; pull-up enables interrupts.
// RULE_08: Direction/option: 00 float, 01 pull-up irq, 10 open-drain, 11 push-pull.
// RULE_09: Each interrupt input can raise an external request on its event.
// RULE_10: Sensitivity is set independently, outside the port registers.
// RULE_11: Interrupt pins are NANDed before detection; one low pin masks others.
// RULE_12: Request latch is hidden and clears when its vector is fetched.
// RULE_13: Changing the sensitivity clears a pending request.
// RULE_14: A claiming peripheral overrides data, direction and option.
// RULE_15: Peripheral output forces the pin to output, drive type from peripheral.
// RULE_16: Peripheral inputs need input mode; pin stays readable via data.
// RULE_17: Input mode with peripheral output: data read returns peripheral output.
// RULE_18: Output mode with peripheral input: peripheral receives the latch.
// RULE_19: Software must not enable alternates on interrupt inputs.
// RULE_20: Analog inputs must be floating; avoid disturbing pins during conversion.
// RULE_21: Write data before switching a pin to output.
// RULE_22: Avoid read-modify-write on the data register.
// RULE_23: Change modes only along safe transition sequences.
// RULE_24: All port registers reset to zero; pins start floating.
// RULE_25: Four events: falling, rising, both edges, falling plus low level.
// RULE_26: Pin levels are synchronised before detection and data reads.
module gpio_port
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pads
    input  wire logic [PORT_W-1:0] pad_in,
    output logic      [PORT_W-1:0] pad_out,
    output logic      [PORT_W-1:0] pad_oe_b,
    output logic      [PORT_W-1:0] pad_pullup,
    // Peripheral alternate functions
    input  wire logic [PORT_W-1:0] alt_out_en,
    input  wire logic [PORT_W-1:0] alt_out_val,
    input  wire logic [PORT_W-1:0] alt_open_drain,
    input  wire logic [PORT_W-1:0] alt_in_en,
    output logic      [PORT_W-1:0] alt_in_val,
    // Interrupt controller
    input  wire logic              vector_fetch,
    output logic                   ext_irq_req
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [PORT_W-1:0] data_latch;
        logic [PORT_W-1:0] direction;
        logic [PORT_W-1:0] option;
        sense_t            sense;
        logic              line_prev;
        logic              pending;
        logic [31:0]       rdata;
    } port_state_t;

    port_state_t state_reg;
    port_state_t state_next;

    logic [PORT_W-1:0] pin_sync;
    logic [PORT_W-1:0] irq_pins;
    logic [PORT_W-1:0] read_view;
    logic              combined_line;
    logic              event_hit;
    logic              wr_acc;
    logic              rd_acc;
    logic              addr_ok;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == DATA_OFFS) || (a == DIR_OFFS) || (a == OPT_OFFS) ||
                    (a == SENSE_OFFS) || (a == STATUS_OFFS);
    endfunction

    // Shared by the clear logic and its assertion
    function automatic logic sense_changes(input logic [31:0] wd, input sense_t cur);
        sense_changes = (sense_t'(wd[SENSE_LSB +: SENSE_W]) != cur);
    endfunction

    // Two-stage synchroniser for pad levels
    gpio_sync u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (pad_in),
        .sync_out (pin_sync)                                   // [RULE_26]
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive: alternate output wins over port settings
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (alt_out_en[i]) begin                           // [RULE_14] [RULE_15]
                pad_out[i]  = 1'b0;
                pad_oe_b[i] = alt_open_drain[i] ? alt_out_val[i] : 1'b0;
                if (!alt_open_drain[i]) begin
                    pad_out[i] = alt_out_val[i];
                end
                pad_pullup[i] = 1'b0;
            end else if (state_reg.direction[i]) begin         // [RULE_05] [RULE_08]
                // Open-drain releases on one, push-pull drives both levels
                pad_out[i]    = state_reg.option[i] ? state_reg.data_latch[i] : 1'b0;
                pad_oe_b[i]   = state_reg.option[i] ? 1'b0 : state_reg.data_latch[i]; // [RULE_06]
                pad_pullup[i] = 1'b0;
            end else begin                                     // [RULE_03] [RULE_04]
                pad_out[i]    = 1'b0;
                pad_oe_b[i]   = 1'b1;
                pad_pullup[i] = state_reg.option[i];           // [RULE_07]
            end
        end
    end

    // Data register view and peripheral input per pin
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin                 // [RULE_01] [RULE_02]
            if (state_reg.direction[i]) begin
                read_view[i] = state_reg.data_latch[i];        // [RULE_05]
            end else if (alt_out_en[i]) begin
                read_view[i] = alt_out_val[i];                 // [RULE_17]
            end else begin
                read_view[i] = pin_sync[i];                    // [RULE_03] [RULE_16]
            end
            if (alt_in_en[i] && state_reg.direction[i]) begin
                alt_in_val[i] = state_reg.data_latch[i];       // [RULE_18]
            end else begin
                alt_in_val[i] = pin_sync[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt source: pull-up inputs NANDed into one line
    assign irq_pins      = ~state_reg.direction & state_reg.option & ~alt_out_en; // [RULE_07]
    // No interrupt pin selected leaves the line idle low
    assign combined_line = ~&(pin_sync | ~irq_pins) & (|irq_pins);             // [RULE_11]

    always_comb begin
        case (state_reg.sense)                                 // [RULE_25] [RULE_10]
            SENSE_FALL_LOW: event_hit = state_reg.line_prev & ~combined_line;
            SENSE_RISE:     event_hit = ~state_reg.line_prev & combined_line;
            SENSE_FALL:     event_hit = state_reg.line_prev & ~combined_line;
            SENSE_BOTH:     event_hit = state_reg.line_prev ^ combined_line;
            default:        event_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign addr_ok = is_mapped(paddr);
    assign wr_acc  = psel && penable && pwrite && addr_ok;
    assign rd_acc  = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = state_reg.rdata;

    always_comb begin
        state_next           = state_reg;
        state_next.line_prev = combined_line;

        // Read data captured in setup so it is stable at the access edge
        if (rd_acc) begin
            state_next.rdata = 32'h0000_0000;
            case (paddr)
                DATA_OFFS:   state_next.rdata[PORT_W-1:0] = read_view;
                DIR_OFFS:    state_next.rdata[PORT_W-1:0] = state_reg.direction;
                OPT_OFFS:    state_next.rdata[PORT_W-1:0] = state_reg.option;
                SENSE_OFFS:  state_next.rdata[SENSE_LSB +: SENSE_W] = state_reg.sense;
                STATUS_OFFS: begin
                    // Request latch stays hidden from software
                    state_next.rdata[ST_PEND_POS] = 1'b0;      // [RULE_12]
                    state_next.rdata[ST_LINE_POS] = combined_line;
                end
                default:     state_next.rdata = 32'h0000_0000;
            endcase
        end

        if (wr_acc) begin
            case (paddr)
                DATA_OFFS: state_next.data_latch = pwdata[PORT_W-1:0]; // [RULE_04]
                DIR_OFFS:  state_next.direction  = pwdata[PORT_W-1:0];
                OPT_OFFS:  state_next.option     = pwdata[PORT_W-1:0];
                SENSE_OFFS: begin
                    state_next.sense = sense_t'(pwdata[SENSE_LSB +: SENSE_W]);
                end
                default: begin
                end
            endcase
        end

        // Clears first, then the event, so a same-cycle event survives
        if (vector_fetch) begin
            state_next.pending = 1'b0;                         // [RULE_12]
        end
        if (wr_acc && paddr == SENSE_OFFS && sense_changes(pwdata, state_reg.sense)) begin
            state_next.pending = 1'b0;                         // [RULE_13]
        end
        if (event_hit) begin
            state_next.pending = 1'b1;                         // [RULE_09]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg            <= '0;                        // [RULE_24]
            state_reg.data_latch <= PORT_RESET;
            state_reg.direction  <= PORT_RESET;
            state_reg.option     <= PORT_RESET;
            state_reg.sense      <= sense_t'(SENSE_RESET);
        end else begin
            state_reg <= state_next;
        end
    end

    // Falling-and-low keeps requesting while the line stays low
    assign ext_irq_req = state_reg.pending ||
                         (state_reg.sense == SENSE_FALL_LOW && (|irq_pins) &&
                          !combined_line);                     // [RULE_25]

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence seq_sense_change;
        wr_acc && paddr == SENSE_OFFS && sense_changes(pwdata, state_reg.sense);
    endsequence

    sequence seq_no_event;
        !event_hit;
    endsequence

    sequence seq_data_read;
        rd_acc && paddr == DATA_OFFS;
    endsequence

    // Reset leaves every unclaimed pin floating
    AST_RESET_FLOAT: assert property (@(posedge clk) // [RULE_24]
        $rose(rst_b) |->
        (pad_oe_b == 8'hFF || alt_out_en != 8'h00))
        else $error("Pins not floating after reset");

    AST_RESET_REGS: assert property (@(posedge clk) // [RULE_24]
        $rose(rst_b) |->
        (state_reg.data_latch == 8'h00 && state_reg.direction == 8'h00 &&
         state_reg.option == 8'h00))
        else $error("Port registers not cleared by reset");

    AST_INPUT_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        (state_reg.direction == 8'h00 && alt_out_en == 8'h00) |->
        pad_oe_b == 8'hFF)
        else $error("Input pin is driven");

    AST_WRITE_LATCH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        (wr_acc && paddr == DATA_OFFS) |->
        state_next.data_latch == pwdata[PORT_W-1:0])
        else $error("Data write missed the latch");

    AST_PUSHPULL_DRIVE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (state_reg.direction[0] && state_reg.option[0] && !alt_out_en[0]) |->
        (!pad_oe_b[0] && pad_out[0] == state_reg.data_latch[0]))
        else $error("Push-pull pin not driving latch");

    AST_OPENDRAIN_RELEASE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (state_reg.direction[0] && !state_reg.option[0] && !alt_out_en[0]) |->
        (pad_oe_b[0] == state_reg.data_latch[0] && !pad_out[0]))
        else $error("Open-drain pin drive wrong");

    // A pull-up fighting a driven output would waste current
    AST_OUTPUT_NO_PULLUP: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
        (|state_reg.direction) |->
        (pad_pullup & state_reg.direction) == 8'h00)
        else $error("Pull-up left on at an output");

    AST_PULLUP_INPUT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
        (!state_reg.direction[3] && !alt_out_en[3]) |->
        pad_pullup[3] == state_reg.option[3])
        else $error("Input pull-up does not follow option");

    AST_ALT_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_15]
        (alt_out_en[0] && !alt_open_drain[0]) |->
        (!pad_oe_b[0] && pad_out[0] == alt_out_val[0]))
        else $error("Peripheral output not forced");

    AST_ALT_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_15]
        (alt_out_en[0] && alt_open_drain[0]) |->
        (!pad_out[0] && pad_oe_b[0] == alt_out_val[0]))
        else $error("Peripheral open-drain output wrong");

    AST_ALT_IN_LATCH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_18]
        (alt_in_en[2] && state_reg.direction[2]) |->
        alt_in_val[2] == state_reg.data_latch[2])
        else $error("Peripheral input not from latch");

    AST_READ_LATCH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        seq_data_read |->
        ((state_next.rdata[PORT_W-1:0] ^ state_reg.data_latch) &
         state_reg.direction) == 8'h00)
        else $error("Output pin read did not return latch");

    AST_READ_PIN: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        seq_data_read |->
        ((state_next.rdata[PORT_W-1:0] ^ pin_sync) &
         ~state_reg.direction & ~alt_out_en) == 8'h00)
        else $error("Input pin read did not return level");

    AST_READ_ALT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_17]
        seq_data_read |->
        ((state_next.rdata[PORT_W-1:0] ^ alt_out_val) &
         ~state_reg.direction & alt_out_en) == 8'h00)
        else $error("Input pin read did not return peripheral output");

    // Two flops of latency; the first two edges after reset still hold zeros
    AST_SYNC_LATENCY: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_26]
        $past(rst_b, 2) |->
        pin_sync == $past(pad_in, 2))
        else $error("Synchroniser latency wrong");

    AST_EVENT_SETS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_09]
        event_hit |=>
        state_reg.pending)
        else $error("Event did not set request");

    AST_SENSE_CLEARS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_13]
        (seq_sense_change and seq_no_event) |=>
        !state_reg.pending)
        else $error("Sensitivity change did not clear request");

    AST_FETCH_CLEARS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
        (vector_fetch && !event_hit) |=>
        !state_reg.pending)
        else $error("Vector fetch did not clear request");

    AST_PEND_HIDDEN: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
        (rd_acc && paddr == STATUS_OFFS) |->
        !state_next.rdata[ST_PEND_POS])
        else $error("Request latch visible to software");

    AST_FALL_LOW_LEVEL: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_25]
        (state_reg.sense == SENSE_FALL_LOW && (|irq_pins) && !combined_line) |->
        ext_irq_req)
        else $error("Low level did not hold request");

    AST_NAND_MASK: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
        (|(irq_pins & ~pin_sync)) |->
        combined_line)
        else $error("Low pin did not mask line");

    // With no source pin the line must not produce events of its own
    AST_IDLE_LINE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
        (irq_pins == 8'h00) |->
        !combined_line)
        else $error("Line active with no interrupt pins");
endmodule

// *** pad_board.sv ***
`timescale 1ns/1ps
module pad_board
    import gpio_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Device side
    input  wire logic [PORT_W-1:0] pad_out,
    input  wire logic [PORT_W-1:0] pad_oe_b,
    input  wire logic [PORT_W-1:0] pad_pullup,
    // Board drivers
    input  wire logic [PORT_W-1:0] ext_en,
    input  wire logic [PORT_W-1:0] ext_val,
    // Resolved level
    output logic      [PORT_W-1:0] pad_in
);
    // A floating pin must never look stable to the synchroniser
    logic [PORT_W-1:0] wander = 8'h55;
    always @(posedge clk) begin
        wander <= ~wander;
    end
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (!pad_oe_b[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_pullup[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = wander[i];
            end
        end
    end
endmodule

// *** tb_gpio_port.sv ***
`timescale 1ns/1ps
module tb_gpio_port
    import gpio_pkg::*;
;
    logic              clk = 1'b0, rst_b = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000, prdata, rdat;
    logic [PORT_W-1:0] pad_in, pad_out, pad_oe_b, pad_pullup, alt_in_val, oe_exp;
    logic [PORT_W-1:0] ext_en = 8'hFF, ext_val = 8'hA5, alt_in_en = 8'h00;
    logic [PORT_W-1:0] alt_out_en = 8'h00, alt_out_val = 8'h00, alt_open_drain = 8'h00;
    logic              vector_fetch = 1'b0, ext_irq_req;
    int                num_errors = 0, checks = 0;
    sense_t            md [6] = '{SENSE_RISE, SENSE_RISE, SENSE_FALL, SENSE_BOTH,
                                  SENSE_BOTH, SENSE_FALL_LOW};
    logic [5:0]        p_from = 6'h11, p_exp = 6'h3D;
    always #50 clk = ~clk;
    gpio_port dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
        .pad_pullup(pad_pullup), .alt_out_en(alt_out_en), .alt_out_val(alt_out_val),
        .alt_open_drain(alt_open_drain), .alt_in_en(alt_in_en), .alt_in_val(alt_in_val),
        .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req));
    pad_board board_u (.clk(clk), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One transfer plus an idle cycle, so back-to-back calls never drive twice at one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, {24'h00_0000, exp});
    endtask
    task automatic fetch();
        vector_fetch <= 1'b1;
        @(posedge clk);
        vector_fetch <= 1'b0;
        cyc(2);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        cyc(2);
        rst_b <= 1'b1;
        cyc(3);
        chk(pad_oe_b, 8'hFF);
        chk(pad_pullup, 8'h00);
        rdchk(DATA_OFFS, 8'hA5);
        rdchk(DIR_OFFS, 8'h00);
        rdchk(OPT_OFFS, 8'h00);
        apb(1'b1, DATA_OFFS, 32'h0000_003C);
        chk(pad_oe_b, 8'hFF);
        rdchk(DATA_OFFS, 8'hA5);
        ext_en <= 8'h00;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OPT_OFFS, {24'h00_0000, {8{m[0]}}});
            apb(1'b1, DIR_OFFS, {24'h00_0000, {8{m[1]}}});
            oe_exp = m[1] ? (m[0] ? 8'h00 : 8'h3C) : 8'hFF;
            chk(pad_oe_b, oe_exp);
            chk(pad_pullup, (m == 1) ? 8'hFF : 8'h00);
            chk(pad_out & ~pad_oe_b, 8'h3C & ~oe_exp);
            if (m[1]) rdchk(DATA_OFFS, 8'h3C);
        end
        apb(1'b1, DIR_OFFS, 32'h0000_0081);
        chk(pad_oe_b, 8'h7E);
        apb(1'b1, 12'h014, 32'h0000_00FF);
        chk(rerr, 1'b1);
        rdchk(12'h014, 8'h00);
        chk(rerr, 1'b1);
        // Pins 0 and 1 interrupt inputs; pin 1 held high so the line follows pin 0 inverted
        ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        apb(1'b1, DIR_OFFS, 32'h0000_0000);
        apb(1'b1, OPT_OFFS, 32'h0000_0003);
        for (int k = 0; k < 6; k++) begin
            ext_val <= {7'h7F, p_from[k]};
            apb(1'b1, SENSE_OFFS, {30'h0, md[k]});
            rdchk(SENSE_OFFS, {6'h00, md[k]});
            cyc(4);
            fetch();
            chk(ext_irq_req, 1'b0);
            ext_val <= {7'h7F, ~p_from[k]};
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ext_irq_req !== 1'b1 && n < 8);
            chk(ext_irq_req, p_exp[k]);
            if (md[k] == SENSE_FALL || md[k] == SENSE_FALL_LOW) begin
                apb(1'b1, SENSE_OFFS, {30'h0, SENSE_RISE});
                chk(ext_irq_req, 1'b0);
            end else begin
                fetch();
                chk(ext_irq_req, 1'b0);
            end
        end
        // Pin 0 low holds the combined line, so pin 1 edges stay hidden
        ext_val <= 8'hFE;
        cyc(4);
        fetch();
        ext_val <= 8'hFC;
        cyc(4);
        ext_val <= 8'hFE;
        cyc(4);
        chk(ext_irq_req, 1'b0);
        rdchk(STATUS_OFFS, 8'h02);
        apb(1'b1, OPT_OFFS, 32'h0000_0000);
        ext_en <= 8'hFE;
        ext_val <= 8'h00;
        alt_out_en <= 8'h01;
        alt_out_val <= 8'h01;
        cyc(4);
        chk({pad_oe_b[0], pad_out[0]}, 2'b01);
        rdchk(DATA_OFFS, 8'h01);
        alt_open_drain <= 8'h01;
        cyc(1);
        chk(pad_oe_b[0], 1'b1);
        alt_out_val <= 8'h00;
        cyc(4);
        chk({pad_oe_b[0], pad_out[0]}, 2'b00);
        rdchk(DATA_OFFS, 8'h00);
        alt_out_en <= 8'h00;
        alt_in_en <= 8'hFF;
        ext_en <= 8'hFF;
        ext_val <= 8'hC3;
        cyc(4);
        chk(alt_in_val, 8'hC3);
        rdchk(DATA_OFFS, 8'hC3);
        apb(1'b1, DATA_OFFS, 32'h0000_005A);
        apb(1'b1, OPT_OFFS, 32'h0000_00FF);
        apb(1'b1, DIR_OFFS, 32'h0000_00FF);
        chk(alt_in_val, 8'h5A);
        finish_test();
    end
endmodule
